/* File: rtl/aaw_area_timing.sv */
// Purpose: area 5A external access sequencer with APB wait control register
// Assumes: ext_wait_n and data_in synchronous to pclk; one access at a time
// Notes: strobes leave through falling-edge flops for half-cycle timing
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/10ps
module aaw_area_timing
   import aaw_pkg::*;
#(
   parameter int AW = 24,
   parameter int DW = 16
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // internal access request
   input wire logic acc_req,
   input wire logic acc_we,
   input wire logic [AW-1:0] acc_addr,
   input wire logic [DW-1:0] acc_wdata,
   output logic acc_done,
   output logic [DW-1:0] acc_rdata,
   // external pins
   output logic [AW-1:0] ext_addr,
   output logic area_chip_select_n,
   output logic rd_strobe_n,
   output logic wr_strobe_n,
   output logic [DW-1:0] data_out,
   output logic data_oe,
   input wire logic [DW-1:0] data_in,
   input wire logic ext_wait_n
);
   logic [31:0] wcr_r;
   logic [31:0] prdata_r;
   aaw_state_e state_r;
   logic cs_r;
   logic strobe_r;
   logic we_r;
   logic mask_r;
   logic [1:0] hold_r;
   logic [4:0] wait_r;
   logic stretch_r;
   logic done_r;
   logic rd_n_r;
   logic wr_n_r;
   logic cnt_load;
   logic [4:0] cnt_val;
   logic cnt_zero;
   logic [4:0] rd_wait;
   logic [4:0] wr_wait;
   logic [2:0] ww_code;
   logic [1:0] sw_code;
   logic held;
   logic setup_ph;
   logic access_ph;
   logic hit_wcr;
   logic hit_stat;

   default clocking chk_cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   assign setup_ph = psel && !penable;
   assign access_ph = psel && penable;
   assign hit_wcr = (paddr == ADDR_WCR);
   assign hit_stat = (paddr == ADDR_STAT);
   assign pready = 1'b1;
   assign pslverr = access_ph && !hit_wcr && !hit_stat;
   assign prdata = prdata_r;

   // only writable bits are stored, so reserved bits stay zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wcr_r <= WCR_RESET;
      else if (access_ph && pwrite && hit_wcr)
         wcr_r <= pwdata & WCR_WMASK;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_r <= 32'h0000_0000;
      else if (setup_ph && !pwrite)
      begin
         prdata_r <= 32'h0000_0000;
         if (hit_wcr)
            prdata_r <= wcr_r & WCR_WMASK;
         else if (hit_stat)
         begin
            prdata_r[STAT_BUSY_BIT] <= (state_r != AAW_IDLE);
            prdata_r[STAT_STRETCH_BIT] <= stretch_r;
         end
      end
   end

   // wait decode from the live register, latched per access
   assign ww_code = wcr_r[WW_LSB +: 3];
   assign sw_code = wcr_r[SW_LSB +: 2];
   assign rd_wait = RD_WAIT_TAB[wcr_r[WR_LSB +: 4]];
   assign wr_wait = (ww_code == 3'h0) ? rd_wait
                    : {2'h0, 3'(ww_code - 3'h1)};
   // the strobe is held past its last wait cycle only when unmasked
   assign held = !mask_r && !ext_wait_n;

   always_comb
   begin
      cnt_load = 1'b0;
      cnt_val = 5'h00;
      unique case (state_r)
         AAW_IDLE:
         begin
            cnt_load = acc_req;
            if (sw_code == 2'h0)
               cnt_val = acc_we ? wr_wait : rd_wait;
            else
               cnt_val = {3'h0, 2'(sw_code - 2'h1)};
         end
         AAW_SETUP:
         begin
            cnt_load = cnt_zero;
            cnt_val = wait_r;
         end
         AAW_STROBE:
         begin
            cnt_load = cnt_zero && !held;
            cnt_val = {3'h0, hold_r};
         end
         AAW_HOLD:
         begin
            cnt_load = 1'b0;
            cnt_val = 5'h00;
         end
      endcase
   end

   aaw_cnt #(.W(5)) u_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .load(cnt_load),
      .load_val(cnt_val),
      .count(),
      .zero(cnt_zero)
   );

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= AAW_IDLE;
         cs_r <= 1'b0;
         strobe_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= 1'b0;
         unique case (state_r)
            AAW_IDLE:
               if (acc_req)
               begin
                  cs_r <= 1'b1;
                  // code 00: strobe flop fires with cs, pin lags half
                  if (sw_code == 2'h0)
                  begin
                     strobe_r <= 1'b1;
                     state_r <= AAW_STROBE;
                  end
                  else
                     state_r <= AAW_SETUP;
               end
            AAW_SETUP:
               if (cnt_zero)
               begin
                  strobe_r <= 1'b1;
                  state_r <= AAW_STROBE;
               end
            AAW_STROBE:
               if (cnt_zero && !held)
               begin
                  strobe_r <= 1'b0;
                  state_r <= AAW_HOLD;
               end
            AAW_HOLD:
               if (cnt_zero)
               begin
                  cs_r <= 1'b0;
                  done_r <= 1'b1;
                  state_r <= AAW_IDLE;
               end
         endcase
      end
   end

   // per-access snapshot so register writes mid-access do no harm
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         we_r <= 1'b0;
         mask_r <= 1'b0;
         hold_r <= 2'h0;
         wait_r <= 5'h00;
         ext_addr <= '0;
         data_out <= '0;
         data_oe <= 1'b0;
      end
      else if (state_r == AAW_IDLE && acc_req)
      begin
         we_r <= acc_we;
         mask_r <= wcr_r[WM_BIT];
         hold_r <= wcr_r[HW_LSB +: 2];
         wait_r <= acc_we ? wr_wait : rd_wait;
         ext_addr <= acc_addr;
         data_out <= acc_wdata;
         data_oe <= acc_we;
      end
      else if (state_r == AAW_HOLD && cnt_zero)
         data_oe <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         acc_rdata <= '0;
         stretch_r <= 1'b0;
      end
      else
      begin
         if (state_r == AAW_IDLE && acc_req)
            stretch_r <= 1'b0;
         else if (state_r == AAW_STROBE && cnt_zero && held)
            stretch_r <= 1'b1;
         if (state_r == AAW_STROBE && cnt_zero && !held && !we_r)
            acc_rdata <= data_in;
      end
   end

   // falling-edge retiming gives the half-cycle setup and hold offsets
   always_ff @(negedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rd_n_r <= 1'b1;
         wr_n_r <= 1'b1;
      end
      else
      begin
         rd_n_r <= !(strobe_r && !we_r);
         wr_n_r <= !(strobe_r && we_r);
      end
   end

   assign rd_strobe_n = rd_n_r;
   assign wr_strobe_n = wr_n_r;
   assign area_chip_select_n = !cs_r;
   assign acc_done = done_r;

   // checking helpers
   logic [2:0] cs_age_r;
   logic [2:0] hold_age_r;
   logic [5:0] strb_len_r;
   logic [31:0] snap_r;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cs_age_r <= 3'h0;
         hold_age_r <= 3'h0;
         strb_len_r <= 6'h00;
         snap_r <= 32'h0000_0000;
      end
      else
      begin
         cs_age_r <= (cs_r && cs_age_r != 3'h7) ? cs_age_r + 3'h1 : 3'h0;
         hold_age_r <= (cs_r && !strobe_r) ? hold_age_r + 3'h1 : 3'h0;
         strb_len_r <= strobe_r ? strb_len_r + 6'h01 : 6'h00;
         if (state_r == AAW_IDLE && acc_req)
            snap_r <= wcr_r;
      end
   end

   logic [4:0] snap_rd;
   logic [2:0] snap_ww;
   assign snap_rd = RD_WAIT_TAB[snap_r[WR_LSB +: 4]];
   assign snap_ww = snap_r[WW_LSB +: 3];

   sequence s_last_wait;
      state_r == AAW_STROBE && cnt_zero;
   endsequence
   sequence s_still_strobing;
      strobe_r && state_r == AAW_STROBE;
   endsequence

   chk_setup_delay: assert property ($rose(strobe_r) |->
      cs_age_r == {1'b0, snap_r[SW_LSB +: 2]})
      else $error("strobe rose at wrong setup delay");
   chk_hold_delay: assert property ($fell(cs_r) |->
      hold_age_r == 3'({1'b0, snap_r[HW_LSB +: 2]} + 3'h1))
      else $error("chip select fell at wrong hold delay");
   chk_read_wait: assert property (
      $fell(strobe_r) && !we_r && mask_r |->
         strb_len_r == {1'b0, snap_rd} + 6'h01)
      else $error("read strobe length wrong");
   chk_write_wait: assert property (
      $fell(strobe_r) && we_r && mask_r |-> strb_len_r ==
         ((snap_ww == 3'h0) ? {1'b0, snap_rd} + 6'h01 : {3'h0, snap_ww}))
      else $error("write strobe length wrong");
   chk_wait_honoured: assert property (
      s_last_wait ##0 (!mask_r && !ext_wait_n) |=> s_still_strobing)
      else $error("unmasked external wait not honoured");
   chk_wait_ignored: assert property (
      s_last_wait ##0 mask_r |=> !strobe_r ##1 (state_r == AAW_HOLD
         || state_r == AAW_IDLE))
      else $error("masked external wait stretched the strobe");
   chk_zero_wait: assert property (
      $rose(strobe_r) && wait_r == 5'h00 && !mask_r && !ext_wait_n
         |=> s_still_strobing)
      else $error("zero-wait access not stretched by external wait");
   chk_reserved_zero: assert property (
      setup_ph && !pwrite && hit_wcr |=> (prdata & ~WCR_WMASK) == 32'h0)
      else $error("reserved bits read nonzero");
   chk_strobe_release: assert property ($fell(strobe_r) |->
      ($past(mask_r) || $past(ext_wait_n)) && $past(cnt_zero))
      else $error("strobe released while wait pending");
endmodule // aaw_area_timing

/* File: rtl/aaw_cnt.sv */
// Purpose: loadable down counter used for setup, wait and hold phases
// Assumes: pclk domain, asynchronous active-low reset
// Notes: holds at zero, load wins over count
`timescale 1ns/10ps
module aaw_cnt #(
   parameter int W = 5
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic load,
   input wire logic [W-1:0] load_val,
   // state
   output logic [W-1:0] count,
   output logic zero
);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count <= '0;
      else if (load)
         count <= load_val;
      else if (count != '0)
         count <= count - 1'b1;
   end

   assign zero = (count == '0);
endmodule // aaw_cnt

/* File: rtl/aaw_pkg.sv */
// Purpose: constants for the area 5A access wait timing block
// Assumes: 32-bit APB, 100 MHz pclk, one register word per offset
// Notes:
package aaw_pkg;
   localparam logic [11:0] ADDR_WCR = 12'h000;
   localparam logic [11:0] ADDR_STAT = 12'h004;
   localparam logic [31:0] WCR_RESET = 32'h0000_0500;
   localparam logic [31:0] WCR_WMASK = 32'h0007_1FC3;
   localparam int WW_LSB = 16;
   localparam int SW_LSB = 11;
   localparam int WR_LSB = 7;
   localparam int WM_BIT = 6;
   localparam int HW_LSB = 0;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_STRETCH_BIT = 1;
   // forbidden codes fall back to the longest legal wait
   localparam logic [4:0] RD_WAIT_TAB [0:15] = '{
      5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08,
      5'h0A, 5'h0C, 5'h0E, 5'h12, 5'h18, 5'h18, 5'h18, 5'h18};
   typedef enum logic [1:0] {
      AAW_IDLE = 2'b00,
      AAW_SETUP = 2'b01,
      AAW_STROBE = 2'b11,
      AAW_HOLD = 2'b10
   } aaw_state_e;
endpackage

/* File: sim/aaw_area_timing_tb_top.sv */
// Purpose: self-checking bench for the area 5A timing block
// Assumes: apb answers at once, partner model on the pins
// Notes: access length is counted from chip select low to done
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
 $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module aaw_area_timing_tb_top;
   import aaw_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic acc_req, acc_we, acc_done, cs_n, rd_n, wr_n, data_oe, ewait_n;
   logic [23:0] acc_addr, ext_addr;
   logic [15:0] acc_wdata, acc_rdata, data_out, data_in;
   logic [15:0] md [0:7];
   logic [3:0] stall;
   logic [32:0] notes [$];
   logic [32:0] nt;
   int num_errors, check_count, cnt, s, h;
   int rdw [0:12] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};
   aaw_area_timing aaw_area_timing_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .acc_req(acc_req), .acc_we(acc_we), .acc_addr(acc_addr),
      .acc_wdata(acc_wdata), .acc_done(acc_done), .acc_rdata(acc_rdata),
      .ext_addr(ext_addr), .area_chip_select_n(cs_n), .rd_strobe_n(rd_n),
      .wr_strobe_n(wr_n), .data_out(data_out), .data_oe(data_oe),
      .data_in(data_in), .ext_wait_n(ewait_n));
   aaw_mem_model aaw_mem_model_i (.pclk(pclk), .presetn(presetn),
      .ext_addr(ext_addr), .area_chip_select_n(cs_n), .rd_strobe_n(rd_n),
      .wr_strobe_n(wr_n), .data_out(data_out), .data_in(data_in),
      .ext_wait_n(ewait_n), .stall(stall));
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // waits for pready however long it takes; the watchdog ends a hang
   task apb(input logic we, input logic [11:0] a, input logic [31:0] d,
            input logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= we;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      `CHK(pslverr, err)
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // a fresh timing is written and read back before every access
   task cfg(input int ww, input int wr, input logic wm);
      logic [31:0] w;
      s = xs() % 4;
      h = xs() % 4;
      w = (ww << WW_LSB) | (s << SW_LSB) | (wr << WR_LSB) | (wm << WM_BIT)
          | (h << HW_LSB);
      apb(1'b1, ADDR_WCR, w, 1'b0);
      apb(1'b0, ADDR_WCR, 32'h0, 1'b0);
      `CHK(rd, w)
   endtask
   task acc(input logic we, input int a, input int dur);
      int k;
      notes.push_back({we, dur[15:0], we ? 16'h0000 : md[a]});
      @(posedge pclk);
      acc_req <= 1'b1;
      acc_we <= we;
      acc_addr <= 24'(a);
      acc_wdata <= md[a];
      @(posedge pclk);
      acc_req <= 1'b0;
      k = 0;
      do
      begin
         @(posedge pclk);
         #1;
         k++;
         if (k == 1)
            `CHK({data_oe, ext_addr}, {we, 24'(a)})
      end
      while (acc_done !== 1'b1 && k < 100);
      if (k >= 100)
         num_errors++;
   endtask
   task close_out();
      $display("errors=%0d checks=%0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // monitor: length and read data of each finished access
   always @(posedge pclk)
   begin
      if (acc_done === 1'b1)
      begin
         nt = notes.pop_front();
         `CHK({cnt[15:0], nt[32] ? 16'h0 : acc_rdata}, nt[31:0])
         cnt = 0;
      end
      else if (cs_n === 1'b0)
         cnt++;
   end
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial
   begin
      #200000;
      num_errors++;
      close_out();
   end
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, acc_req, acc_we} = '0;
      {acc_addr, acc_wdata, cnt, num_errors, check_count} = '0;
      seed = 32'd15777;
      stall = 4'h0;
      presetn = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ADDR_WCR, 32'h0, 1'b0);
      `CHK(rd, WCR_RESET)
      apb(1'b0, 12'h008, 32'h0, 1'b1);
      for (int ww = 0; ww < 8; ww++)
      begin
         md[ww] = 16'(xs());
         cfg(ww, ww + 3, 1'b1);
         acc(1'b1, ww, s + (ww ? ww - 1 : rdw[ww + 3]) + 2 + h);
      end
      for (int wr = 0; wr < 13; wr++)
      begin
         cfg(xs() % 8, wr, 1'b1);
         acc(1'b0, wr % 8, s + rdw[wr] + 2 + h);
      end
      stall = 4'h3;
      cfg(1, 0, 1'b0);
      acc(1'b0, 1, s + 3 + 2 + h);
      // status must show the stretch, and not busy
      apb(1'b0, ADDR_STAT, 32'h0, 1'b0);
      `CHK(rd, 32'h1 << STAT_STRETCH_BIT)
      cfg(1, 0, 1'b1);
      acc(1'b0, 2, s + 2 + h);
      apb(1'b0, ADDR_STAT, 32'h0, 1'b0);
      `CHK(rd, 32'h0000_0000)
      cfg(1, 7, 1'b0);
      acc(1'b0, 3, s + 8 + 2 + h);
      cfg(0, 0, 1'b0);
      acc(1'b1, 4, s + 3 + 2 + h);
      repeat (3) @(posedge pclk);
      close_out();
   end
endmodule // aaw_area_timing_tb_top

/* File: sim/aaw_mem_model.sv */
// Purpose: external sram-like partner on the area 5A pins
// Assumes: one access at a time, low address byte picks a word
// Notes: a released data bus shows the inverted last value, never stale
`timescale 1ns/10ps
module aaw_mem_model
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // pins from the block
   input wire logic [23:0] ext_addr,
   input wire logic area_chip_select_n,
   input wire logic rd_strobe_n,
   input wire logic wr_strobe_n,
   input wire logic [15:0] data_out,
   // pins to the block
   output logic [15:0] data_in,
   output logic ext_wait_n,
   // bench control: edges of wait at the start of each strobe
   input wire logic [3:0] stall
);
   logic [15:0] mem [0:255];
   logic [15:0] last_r;
   logic [3:0] wcnt_r;
   logic strb;
   assign strb = !area_chip_select_n && !(rd_strobe_n && wr_strobe_n);
   assign data_in = (strb && !rd_strobe_n) ? mem[ext_addr[7:0]] : ~last_r;
   // slow device: wait held low for the first stall edges of a strobe
   assign ext_wait_n = !(strb && wcnt_r < stall);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         last_r <= 16'h0000;
         wcnt_r <= 4'h0;
      end
      else
      begin
         last_r <= data_in;
         wcnt_r <= !strb ? 4'h0 : wcnt_r + ((wcnt_r != 4'hF) ? 4'h1 : 4'h0);
      end
   end
   always @(posedge wr_strobe_n)
      if (!area_chip_select_n)
         mem[ext_addr[7:0]] <= data_out;
endmodule // aaw_mem_model
